// [design/gsf_pkg.sv]
// Package with register map, field layout and reset values of the general status flags block
package gsf_pkg;

  // ----------------------------------------------------------------
  // Bus, flag and DAC code widths and responses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int FLAG_W = 11;
  localparam int CODE_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_GENERAL_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DAC_CODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DAC_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DAC_OUT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SUMMARY = 8'h18;

  // ----------------------------------------------------------------
  // Field positions of general_status, and of the slew enable bit in the DAC control register
  // ----------------------------------------------------------------
  localparam int BIT_SELF_TEST_COMPLETE = 10;
  localparam int BIT_SELF_TEST_FAILED = 9;
  localparam int BIT_RESET_OCCURRED = 8;
  localparam int BIT_SLEW_IDLE = 7;
  localparam int BIT_ADC_EOC = 6;
  localparam int BIT_ADC_BUSY = 5;
  localparam int BIT_OUTPUT_SUPPLY_HIGH = 4;
  localparam int BIT_BREAK_STOP_ERR = 3;
  localparam int BIT_BREAK_PARITY_ERR = 2;
  localparam int BIT_CHAR_STOP_ERR = 1;
  localparam int BIT_CHAR_PARITY_ERR = 0;
  localparam int BIT_SLEW_EN = 0;

  // Bits 10,9,8,6,3,2,1,0 are sticky; 10,9,7,6,3,2,1,0 may reach the interrupt
  localparam logic [FLAG_W-1:0] STICKY_BITS = 11'h74f;
  localparam logic [FLAG_W-1:0] MASKABLE_BITS = 11'h6cf;
  localparam logic [FLAG_W-1:0] STICKY_RST = 11'h100;
  localparam logic [CODE_W-1:0] SLEW_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic [FLAG_W-1:0] sticky;
    logic [FLAG_W-1:0] mask;
    logic [FLAG_W-1:0] irq_st;
    logic [CODE_W-1:0] code;
    logic slew_en;
    logic [CODE_W-1:0] dac_out;
    logic idle_q;
    logic irq;
  } gsf_state_s;

  localparam gsf_state_s STATE_RST = '{
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
    arready: 1'b1, rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0000_0000,
    aw_held: 1'b0, awaddr: 8'h00, w_held: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0,
    sticky: STICKY_RST, mask: 11'h000, irq_st: 11'h000,
    code: 16'h0000, slew_en: 1'b0, dac_out: 16'h0000, idle_q: 1'b1, irq: 1'b0
  };

endpackage

// [design/gsf_top.sv]
// General status flags register bank with DAC slew tracking, serial error checks and AXI4-Lite access
//
// How it works
// - Self-test completion sets sticky bit 10, maskable, kept until the register is read.
// - Self-test failure sets sticky maskable bit 9; zero means the test passed.
// - Bit 8 shows reset occurred, resets to one, clears on read, never interrupts.
// - Reading clears sticky bits, but a still-present condition keeps its bit set.
// - Bit 7 low while DAC output ramps, high once it equals the code.
// - Without slew control bit 7 rises within 3 clocks of a new code.
// - With slew control, reaching the code raises a maskable interrupt event.
// - Turning slew control off mid-ramp steps the output straight to the code.
// - Diagnostic ADC conversion end sets sticky maskable bit 6.
// - Bit 5 is live ADC activity, status only, no interrupt.
// - Bit 4 is live output supply high indication, status only, no interrupt.
// - Break character with a bad stop bit sets sticky maskable bit 3.
// - Break character failing odd parity sets sticky maskable bit 2.
// - Ordinary character with a bad stop bit sets sticky maskable bit 1.
// - Ordinary character failing odd parity sets sticky maskable bit 0.
// - General summary is the OR of all unmasked bits of the register.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module gsf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gsf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gsf_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [gsf_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gsf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gsf_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic self_test_done,
  input wire logic self_test_fail,
  input wire logic adc_eoc,
  input wire logic adc_busy,
  input wire logic output_supply_high,
  input wire logic char_valid,
  input wire logic char_is_break,
  input wire logic [7:0] char_data,
  input wire logic char_parity,
  input wire logic char_stop,
  output logic [gsf_pkg::CODE_W-1:0] dac_out,
  output logic irq
);
  import gsf_pkg::*;

  gsf_state_s s_r;
  gsf_state_s s_nxt;

  // ----------------------------------------------------------------
  // Byte-lane merge for partial writes
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] gsf_merge(input logic [DATA_W-1:0] old_v,
                                                  input logic [DATA_W-1:0] new_v,
                                                  input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic slew_idle;
  logic par_ok;
  logic [FLAG_W-1:0] set_v;
  logic [FLAG_W-1:0] ev_v;
  logic [FLAG_W-1:0] status_v;
  logic [FLAG_W-1:0] clr_v;
  logic [FLAG_W-1:0] w1c_v;
  logic summary;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic [DATA_W-1:0] merged;
  logic [CODE_W-1:0] diff;

  always_comb begin
    s_nxt = s_r;
    clr_v = '0;
    w1c_v = '0;
    merged = '0;
    wa = {s_r.awaddr[ADDR_W-1:2], 2'b00};
    ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};

    // ----------------------------------------------------------------
    // Flag sources
    // ----------------------------------------------------------------
    slew_idle = (s_r.dac_out == s_r.code);
    par_ok = ^{char_data, char_parity};
    set_v = '0;
    set_v[BIT_SELF_TEST_COMPLETE] = self_test_done;
    set_v[BIT_SELF_TEST_FAILED] = self_test_fail;
    set_v[BIT_ADC_EOC] = adc_eoc;
    set_v[BIT_BREAK_STOP_ERR] = char_valid & char_is_break & ~char_stop;
    set_v[BIT_BREAK_PARITY_ERR] = char_valid & char_is_break & ~par_ok;
    set_v[BIT_CHAR_STOP_ERR] = char_valid & ~char_is_break & ~char_stop;
    set_v[BIT_CHAR_PARITY_ERR] = char_valid & ~char_is_break & ~par_ok;

    status_v = s_r.sticky & STICKY_BITS;
    status_v[BIT_SLEW_IDLE] = slew_idle;
    status_v[BIT_ADC_BUSY] = adc_busy;
    status_v[BIT_OUTPUT_SUPPLY_HIGH] = output_supply_high;
    summary = |(status_v & s_r.mask & MASKABLE_BITS);

    // Interrupt events; slew completion counts only under slew control
    ev_v = set_v & MASKABLE_BITS;
    ev_v[BIT_SLEW_IDLE] = slew_idle & ~s_r.idle_q & s_r.slew_en;
    s_nxt.idle_q = slew_idle;

    // ----------------------------------------------------------------
    // Write channels
    // ----------------------------------------------------------------
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
      s_nxt.awready = 1'b0;
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
      s_nxt.wready = 1'b0;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      if (wa == OFS_IRQ_MASK) begin
        merged = gsf_merge({21'h000000, s_r.mask}, s_r.wdata, s_r.wstrb);
        s_nxt.mask = merged[FLAG_W-1:0] & MASKABLE_BITS;
      end else if (wa == OFS_DAC_CODE) begin
        merged = gsf_merge({16'h0000, s_r.code}, s_r.wdata, s_r.wstrb);
        s_nxt.code = merged[CODE_W-1:0];
      end else if (wa == OFS_DAC_CTRL) begin
        merged = gsf_merge({31'h00000000, s_r.slew_en}, s_r.wdata, s_r.wstrb);
        s_nxt.slew_en = merged[BIT_SLEW_EN];
      end else if (wa == OFS_IRQ_STATUS) begin
        merged = gsf_merge(32'h0000_0000, s_r.wdata, s_r.wstrb);
        w1c_v = merged[FLAG_W-1:0];
      end else if (wa == OFS_GENERAL_STATUS || wa == OFS_DAC_OUT || wa == OFS_IRQ_SUMMARY) begin
        s_nxt.bresp = RESP_OKAY;
      end else begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      if (ra == OFS_GENERAL_STATUS) begin
        s_nxt.rdata = {21'h000000, status_v};
        clr_v = status_v & STICKY_BITS;
      end else if (ra == OFS_IRQ_MASK) begin
        s_nxt.rdata = {21'h000000, s_r.mask};
      end else if (ra == OFS_DAC_CODE) begin
        s_nxt.rdata = {16'h0000, s_r.code};
      end else if (ra == OFS_DAC_CTRL) begin
        s_nxt.rdata = {31'h00000000, s_r.slew_en};
      end else if (ra == OFS_DAC_OUT) begin
        s_nxt.rdata = {16'h0000, s_r.dac_out};
      end else if (ra == OFS_IRQ_STATUS) begin
        s_nxt.rdata = {21'h000000, s_r.irq_st};
      end else if (ra == OFS_IRQ_SUMMARY) begin
        s_nxt.rdata = {31'h00000000, summary};
      end else begin
        s_nxt.rresp = RESP_SLVERR;
      end
    end

    // ----------------------------------------------------------------
    // Sticky update: set wins over the read clear
    // ----------------------------------------------------------------
    s_nxt.sticky = ((s_r.sticky & ~clr_v) | set_v) & STICKY_BITS;
    s_nxt.irq_st = ((s_r.irq_st & ~w1c_v) | ev_v) & MASKABLE_BITS;
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.mask);

    // ----------------------------------------------------------------
    // DAC output tracking
    // ----------------------------------------------------------------
    diff = '0;
    if (!s_r.slew_en) begin
      s_nxt.dac_out = s_r.code;
    end else if (s_r.dac_out < s_r.code) begin
      diff = s_r.code - s_r.dac_out;
      s_nxt.dac_out = (diff > SLEW_STEP) ? s_r.dac_out + SLEW_STEP : s_r.code;
    end else if (s_r.dac_out > s_r.code) begin
      diff = s_r.dac_out - s_r.code;
      s_nxt.dac_out = (diff > SLEW_STEP) ? s_r.dac_out - SLEW_STEP : s_r.code;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
  assign dac_out = s_r.dac_out;
  assign irq = s_r.irq;

endmodule

// [dv/gsf_chk.sv]
// Port checker for the general status flags block
`timescale 1ns/1ps
module gsf_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gsf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [gsf_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic self_test_fail,
  input wire logic adc_busy,
  input wire logic output_supply_high
);
  import gsf_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence gs_take; ar_take ##0 s_axi_araddr == OFS_GENERAL_STATUS; endsequence
  sequence fail_held; self_test_fail ##1 (self_test_fail && s_axi_arvalid && s_axi_arready); endsequence
  AST_RD_LAT: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken in read");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("response dropped");
  AST_STICKY_HELD: assert property (fail_held |=> s_axi_rdata[BIT_SELF_TEST_FAILED])
    else $error("held flag cleared");
  AST_LIVE_BUSY: assert property (gs_take |=> s_axi_rdata[BIT_ADC_BUSY] == $past(adc_busy))
    else $error("busy flag wrong");
  AST_LIVE_SUPPLY: assert property (gs_take |=> s_axi_rdata[BIT_OUTPUT_SUPPLY_HIGH] == $past(output_supply_high))
    else $error("supply flag wrong");
endmodule

bind gsf_top gsf_chk u_gsf_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .self_test_fail, .adc_busy, .output_supply_high);

// [dv/gsf_host.sv]
// Register bus master model of the host
`timescale 1ns/1ps
module gsf_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the general status flags block
`timescale 1ns/1ps
module tb;
  import gsf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic self_test_done = 1'b0, self_test_fail = 1'b0, adc_eoc = 1'b0, adc_busy = 1'b0, output_supply_high = 1'b0;
  logic char_valid = 1'b0, char_is_break = 1'b0, char_parity = 1'b1, char_stop = 1'b1;
  logic [7:0] char_data = 8'h00;
  logic [15:0] dac_out;
  int mismatches = 0;
  int checks_done = 0;
  always #5 aclk = ~aclk;
  gsf_top u_gsf_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .self_test_done, .self_test_fail, .adc_eoc, .adc_busy, .output_supply_high,
    .char_valid, .char_is_break, .char_data, .char_parity, .char_stop, .dac_out, .irq);
  gsf_host u_gsf_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_gsf_host.wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic gs(input logic [10:0] e);
    logic [31:0] d;
    logic [1:0] r;
    u_gsf_host.rd(OFS_GENERAL_STATUS, d, r);
    chk(d, {21'h0, e});
  endtask
  task automatic chr(input logic b, input logic p, input logic s);
    @(posedge aclk);
    char_valid <= 1'b1;
    char_is_break <= b;
    char_parity <= p;
    char_stop <= s;
    @(posedge aclk);
    char_valid <= 1'b0;
  endtask
  task automatic wait_irq(input logic e);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    gs(11'h180);
    gs(11'h080);
    u_gsf_host.rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    u_gsf_host.wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_events();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_IRQ_MASK, 32'h7ff);
    chr(1'b0, 1'b1, 1'b1);
    gs(11'h080);
    @(posedge aclk);
    {self_test_done, self_test_fail, adc_eoc} <= 3'h7;
    @(posedge aclk);
    {self_test_done, self_test_fail, adc_eoc} <= 3'h0;
    chr(1'b0, 1'b0, 1'b1);
    chr(1'b0, 1'b1, 1'b0);
    chr(1'b1, 1'b0, 1'b1);
    chr(1'b1, 1'b1, 1'b0);
    wait_irq(1'b1);
    u_gsf_host.rd(OFS_IRQ_STATUS, d, r);
    chk(d, 32'h0000_064f);
    gs(11'h6cf);
    gs(11'h080);
    wr(OFS_IRQ_STATUS, 32'h7ff);
    wr(OFS_IRQ_MASK, 32'h0);
    u_gsf_host.rd(OFS_IRQ_SUMMARY, d, r);
    chk(d, 32'h0000_0000);
    chr(1'b0, 1'b0, 1'b1);
    wait_irq(1'b0);
    gs(11'h081);
    wr(OFS_IRQ_STATUS, 32'h7ff);
    wr(OFS_IRQ_MASK, 32'h7ff);
    u_gsf_host.rd(OFS_IRQ_SUMMARY, d, r);
    chk(d, 32'h0000_0001);
  endtask
  task automatic t_live();
    @(posedge aclk);
    {adc_busy, output_supply_high} <= 2'h3;
    gs(11'h0b0);
    wait_irq(1'b0);
    self_test_fail <= 1'b1;
    gs(11'h2b0);
    gs(11'h2b0);
    @(posedge aclk);
    {adc_busy, output_supply_high, self_test_fail} <= 3'h0;
    gs(11'h280);
    gs(11'h080);
    wr(OFS_IRQ_STATUS, 32'h7ff);
  endtask
  task automatic t_dac();
    wr(OFS_DAC_CODE, 32'h5);
    repeat (3) if (dac_out !== 16'h5) @(posedge aclk);
    chk({16'h0, dac_out}, 32'h5);
    gs(11'h080);
    wait_irq(1'b0);
    wr(OFS_DAC_CTRL, 32'h1);
    wr(OFS_DAC_CODE, 32'h15);
    gs(11'h000);
    repeat (40) if (dac_out !== 16'h15) @(posedge aclk);
    chk({16'h0, dac_out}, 32'h15);
    wait_irq(1'b1);
    gs(11'h080);
    wr(OFS_DAC_CTRL, 32'h0);
    wr(OFS_DAC_CTRL, 32'h1);
    wr(OFS_DAC_CODE, 32'h100);
    wr(OFS_DAC_CTRL, 32'h0);
    repeat (3) if (dac_out !== 16'h100) @(posedge aclk);
    chk({16'h0, dac_out}, 32'h100);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_events();
    t_live();
    t_dac();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end
endmodule
